// ==== verification/speech_encoder_model.sv ====
// Encoder stand-in: emits coded frames one bit per cycle, header word first.
// Assumes each frame is started by the caller just after a rising clock edge.
`timescale 1ns/100ps
module speech_encoder_model (
  // Clock
  input  wire logic i_clock,
  // Frame bit stream
  output logic      o_bit_valid,
  output logic      o_bit_data,
  output logic      o_bit_last
);
  logic data_r;
  logic idle_r;

  initial begin
    o_bit_valid = 1'b0;
    o_bit_last  = 1'b0;
    data_r      = 1'b0;
    idle_r      = 1'b0;
  end

  // Idle line keeps toggling so a stale bit never passes for data
  always @(posedge i_clock) begin
    idle_r <= ~idle_r;
  end

  assign o_bit_data = o_bit_valid ? data_r : idle_r;

  // Bit 15 of the header word leaves first; payload is a filler pattern
  task automatic send_frame(input int len, input logic [15:0] hdr);
    for (int i = 0; i < len; i++) begin
      o_bit_valid <= 1'b1;
      data_r      <= (i < 16) ? hdr[15 - i] : i[0];
      o_bit_last  <= (i == len - 1);
      @(posedge i_clock);
    end
    o_bit_valid <= 1'b0;
    o_bit_last  <= 1'b0;
  endtask : send_frame
endmodule : speech_encoder_model

// ==== verification/speech_frame_field_parser_tb.sv ====
// Testbench for the speech frame field parser: frames from the encoder model,
// registers over APB, decoded fields compared per rate.
// Assumes a zero-wait-state APB slave and a one-cycle done pulse.
`timescale 1ns/100ps
module speech_frame_field_parser_tb;
  import frame_parser_pkg::*;

  logic        clock;
  logic        srst;
  logic        bit_valid;
  logic        bit_data;
  logic        bit_last;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  frame_info_t info;
  frame_info_t exp_info;
  logic        done;
  logic        bad;
  int          miscompares;
  int          num_checks;
  int          good_n;
  int          bad_n;
  logic [31:0] rd;
  logic        err;

  always #2.5 clock = ~clock;

  speech_encoder_model enc (.i_clock(clock), .o_bit_valid(bit_valid), .o_bit_data(bit_data),
                            .o_bit_last(bit_last));

  speech_frame_field_parser DUT (.i_clock(clock), .i_srst(srst), .i_bit_valid(bit_valid),
    .i_bit_data(bit_data), .i_bit_last(bit_last), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .o_frame_info(info), .o_frame_done(done),
    .o_frame_bad(bad));

  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Setup cycle, then access held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run(input int len, input logic [15:0] hdr, input rate_t r, input core_t c,
                     input ext_t e);
    @(posedge clock);
    enc.send_frame(len, hdr);
    #1;
    chk(32'(done), 32'h1);
    chk(32'(bad), 32'(r == RATE_BAD));
    chk(32'(info.rate), 32'(r));
    if (r != RATE_BAD) begin
      chk(32'(info.core), 32'(c));
      chk(32'(info.ext), 32'(e));
      good_n++;
    end else begin
      bad_n++;
    end
    @(posedge clock);
    #1;
    chk(32'(done), 32'h0);
  endtask : run

  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    clock = 1'b0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    num_checks = 0;
    good_n = 0;
    bad_n = 0;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    #1;
    chk(32'(info.rate), 32'(RATE_BAD));
    chk(32'(done), 32'h0);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk(rd, CTRL_RESET);
    run(56, 16'hA000, RATE_2K8, CORE_LINEAR_PREDICTION, EXT_NONE);
    chk(32'(info.bandwidth_field), 32'(BW_WIDE));
    run(56, 16'h8000, RATE_2K8, CORE_LINEAR_PREDICTION, EXT_NONE);
    chk(32'(info.bandwidth_field), 32'(BW_NARROW));
    run(144, 16'hC000, RATE_7K2, CORE_HIGH_QUALITY, EXT_NONE);
    chk(32'(info.bandwidth_field), 32'(BW_WIDE));
    run(160, 16'h4000, RATE_8K0, CORE_LINEAR_PREDICTION, EXT_NONE);
    run(192, 16'h7800, RATE_9K6, CORE_TRANSFORM_EXCITE, EXT_GAP_FILLING);
    run(192, 16'h5800, RATE_9K6, CORE_LINEAR_PREDICTION, EXT_TIME_DOMAIN);
    run(264, 16'h4A00, RATE_13K2, CORE_TRANSFORM_EXCITE, EXT_NONE);
    chk(32'(info.transform_coder_class), 32'h2);
    run(264, 16'h4C00, RATE_13K2, CORE_HIGH_QUALITY, EXT_NONE);
    run(264, 16'h4400, RATE_13K2, CORE_LINEAR_PREDICTION, EXT_FREQ_DOMAIN);
    run(264, 16'h4000, RATE_13K2, CORE_LINEAR_PREDICTION, EXT_TIME_DOMAIN);
    run(264, 16'h0000, RATE_13K2, CORE_LINEAR_PREDICTION, EXT_NONE);
    run(264, 16'h8800, RATE_13K2, CORE_TRANSFORM_EXCITE, EXT_GAP_FILLING);
    run(328, 16'hBC00, RATE_16K4, CORE_TRANSFORM_EXCITE, EXT_GAP_FILLING);
    chk(32'(info.bandwidth_field), 32'(BW_SUPER));
    run(328, 16'hC000, RATE_16K4, CORE_LINEAR_PREDICTION, EXT_TIME_DOMAIN);
    run(488, 16'h3E00, RATE_24K4, CORE_HIGH_QUALITY, EXT_NONE);
    chk(32'({info.prev_linear_prediction, info.rate_16k}), 32'h3);
    run(488, 16'h3A00, RATE_24K4, CORE_HIGH_QUALITY, EXT_NONE);
    chk(32'({info.prev_linear_prediction, info.rate_16k}), 32'h0);
    run(488, 16'h9200, RATE_24K4, CORE_TRANSFORM_EXCITE, EXT_GAP_FILLING);
    chk(32'(info.transform_coder_class), 32'h1);
    run(488, 16'hC000, RATE_24K4, CORE_LINEAR_PREDICTION, EXT_TIME_DOMAIN);
    exp_info = '{rate: RATE_24K4, core: CORE_LINEAR_PREDICTION, ext: EXT_TIME_DOMAIN,
                 bandwidth_field: BW_FULL, coder_class_field: 4'h0,
                 transform_coder_class: 2'h0, prev_linear_prediction: 1'b0,
                 rate_16k: 1'b0, signalling_bits: 4'h6};
    apb(1'b0, RESULT_OFFSET, 32'h0);
    chk(rd, {3'b000, exp_info});
    run(100, 16'hFFFF, RATE_BAD, CORE_LINEAR_PREDICTION, EXT_NONE);
    run(55, 16'hA000, RATE_BAD, CORE_LINEAR_PREDICTION, EXT_NONE);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, {bad_n[15:0], good_n[15:0]});
    // Bits offered while disabled must leave no trace
    apb(1'b1, CTRL_OFFSET, 32'h0);
    @(posedge clock);
    enc.send_frame(56, 16'hA000);
    #1;
    chk(32'(done), 32'h0);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, {bad_n[15:0], good_n[15:0]});
    apb(1'b1, 8'h0C, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk(rd[0 +: 1], 1'b1);
    apb(1'b1, CTRL_OFFSET, 32'h3);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0);
    report_and_stop();
  end
endmodule : speech_frame_field_parser_tb

// ==== verilog/frame_parser_pkg.sv ====
// Constants, encodings and carrier types for the speech frame field parser.
// Assumes one system clock and an APB master with 32-bit data.
package frame_parser_pkg;

  // APB register byte addresses
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] RESULT_OFFSET = 8'h08;

  // Control field positions and reset value
  localparam int          CTRL_ENABLE_BIT = 0;
  localparam int          CTRL_CLEAR_BIT  = 1;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;

  // Supported frame sizes in bits, then the saturation limit of the length count
  localparam logic [9:0] LEN_LOW_RATE = 10'h038;  // 56
  localparam logic [9:0] LEN_7K2      = 10'h090;  // 144
  localparam logic [9:0] LEN_8K0      = 10'h0A0;  // 160
  localparam logic [9:0] LEN_9K6      = 10'h0C0;  // 192
  localparam logic [9:0] LEN_13K2     = 10'h108;  // 264
  localparam logic [9:0] LEN_16K4     = 10'h148;  // 328
  localparam logic [9:0] LEN_24K4     = 10'h1E8;  // 488
  localparam logic [9:0] LEN_MAX      = 10'h3FF;

  // Header capture depth
  localparam int HDR_BITS = 16;

  // Bandwidth field codes
  localparam logic [1:0] BW_NARROW = 2'h0;
  localparam logic [1:0] BW_WIDE   = 2'h1;
  localparam logic [1:0] BW_SUPER  = 2'h2;
  localparam logic [1:0] BW_FULL   = 2'h3;

  // Coder class codes that select the transform excitation core
  localparam logic [2:0] CT_9K6_TRANSFORM  = 3'h7;
  localparam logic [2:0] CT_16K4_TRANSFORM = 3'h7;

  // Signalling bit counts per layout
  localparam logic [3:0] SIG_LOW_RATE = 4'h3;
  localparam logic [3:0] SIG_JOINT4   = 4'h4;
  localparam logic [3:0] SIG_9K6      = 4'h5;
  localparam logic [3:0] SIG_13K2     = 4'h5;
  localparam logic [3:0] SIG_16K4     = 4'h6;
  localparam logic [3:0] SIG_24K4     = 4'h4;

  typedef enum logic [7:0] {
    RATE_BAD  = 8'h01,
    RATE_2K8  = 8'h02,
    RATE_7K2  = 8'h04,
    RATE_8K0  = 8'h08,
    RATE_9K6  = 8'h10,
    RATE_13K2 = 8'h20,
    RATE_16K4 = 8'h40,
    RATE_24K4 = 8'h80
  } rate_t;

  typedef enum logic [2:0] {
    CORE_LINEAR_PREDICTION = 3'h1,
    CORE_HIGH_QUALITY      = 3'h2,
    CORE_TRANSFORM_EXCITE  = 3'h4
  } core_t;

  typedef enum logic [3:0] {
    EXT_NONE        = 4'h1,
    EXT_TIME_DOMAIN = 4'h2,
    EXT_GAP_FILLING = 4'h4,
    EXT_FREQ_DOMAIN = 4'h8
  } ext_t;

  typedef struct packed {
    rate_t      rate;
    core_t      core;
    ext_t       ext;
    logic [1:0] bandwidth_field;
    logic [3:0] coder_class_field;
    logic [1:0] transform_coder_class;
    logic       prev_linear_prediction;
    logic       rate_16k;
    logic [3:0] signalling_bits;
  } frame_info_t;

endpackage : frame_parser_pkg

// ==== verilog/speech_frame_field_parser.sv ====
// Speech frame field parser: takes coded frame bits one per cycle and
// decodes the leading signalling fields once the frame length is known.
// Assumes a bit stream source on i_clock and an APB master on i_clock.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module speech_frame_field_parser (
  // Clock and reset
  input  wire logic                         i_clock,
  input  wire logic                         i_srst,
  // Coded frame bit stream
  input  wire logic                         i_bit_valid,
  input  wire logic                         i_bit_data,
  input  wire logic                         i_bit_last,
  // APB slave
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [7:0]                   i_paddr,
  input  wire logic [31:0]                  i_pwdata,
  output logic                              o_pready,
  output logic [31:0]                       o_prdata,
  output logic                              o_pslverr,
  // Decoded frame towards the core decoders
  output frame_parser_pkg::frame_info_t     o_frame_info,
  output logic                              o_frame_done,
  output logic                              o_frame_bad
);
  import frame_parser_pkg::*;

  logic [HDR_BITS-1:0] hdr_r;
  logic [9:0]          len_r;
  logic [31:0]         ctrl_r;
  logic [15:0]         good_count_r;
  logic [15:0]         bad_count_r;
  frame_info_t         info_r;
  frame_info_t         info_nxt;
  logic [HDR_BITS-1:0] hdr_nxt;
  logic [9:0]          len_nxt;
  logic                take_bit;
  logic                setup;
  logic                enable;

  assign enable   = ctrl_r[CTRL_ENABLE_BIT];
  assign take_bit = i_bit_valid & enable;
  assign setup    = i_psel & ~i_penable;

  // Bits beyond the header window only advance the length count
  always_comb begin
    hdr_nxt = hdr_r;
    if (len_r < 10'(HDR_BITS)) begin
      hdr_nxt = {hdr_r[HDR_BITS-2:0], i_bit_data};
    end
    len_nxt = (len_r == LEN_MAX) ? len_r : len_r + 10'h001;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      hdr_r <= '0;
      len_r <= '0;
    end else if (take_bit) begin
      if (i_bit_last) begin
        hdr_r <= '0;
        len_r <= '0;
      end else begin
        hdr_r <= hdr_nxt;
        len_r <= len_nxt;
      end
    end
  end

  // Decode is done on the final bit, using the completed header window
  always_comb begin
    logic [HDR_BITS-1:0] h;
    logic [9:0]          n;
    h = hdr_nxt;
    n = len_nxt;
    info_nxt = '{rate: RATE_BAD, core: CORE_LINEAR_PREDICTION, ext: EXT_NONE,
                 bandwidth_field: '0, coder_class_field: '0,
                 transform_coder_class: '0, prev_linear_prediction: 1'b0,
                 rate_16k: 1'b0, signalling_bits: '0};
    if (n == LEN_LOW_RATE) begin
      info_nxt.rate              = RATE_2K8;
      info_nxt.coder_class_field = {1'b0, h[15:13]};
      info_nxt.bandwidth_field   = h[13] ? BW_WIDE : BW_NARROW;
      info_nxt.signalling_bits   = SIG_LOW_RATE;
    end else if (n == LEN_7K2 || n == LEN_8K0) begin
      info_nxt.rate              = (n == LEN_7K2) ? RATE_7K2 : RATE_8K0;
      info_nxt.coder_class_field = h[15:12];
      info_nxt.bandwidth_field   = {1'b0, h[14]};
      info_nxt.core = h[15] ? CORE_HIGH_QUALITY : CORE_LINEAR_PREDICTION;
      info_nxt.ext               = EXT_NONE;
      info_nxt.signalling_bits   = SIG_JOINT4;
    end else if (n == LEN_9K6) begin
      info_nxt.rate              = RATE_9K6;
      info_nxt.bandwidth_field   = h[15:14];
      info_nxt.coder_class_field = {1'b0, h[13:11]};
      info_nxt.core = (h[13:11] == CT_9K6_TRANSFORM) ? CORE_TRANSFORM_EXCITE
                                                     : CORE_LINEAR_PREDICTION;
      if (h[15:14] == BW_WIDE || h[15:14] == BW_SUPER) begin
        info_nxt.ext = (h[13:11] == CT_9K6_TRANSFORM) ? EXT_GAP_FILLING
                                                      : EXT_TIME_DOMAIN;
      end
      info_nxt.signalling_bits   = SIG_9K6;
    end else if (n == LEN_13K2) begin
      info_nxt.rate              = RATE_13K2;
      info_nxt.bandwidth_field   = h[15:14];
      info_nxt.coder_class_field = {1'b0, h[13:11]};
      info_nxt.signalling_bits   = SIG_13K2;
      if (h[11]) begin
        info_nxt.signalling_bits = SIG_13K2 + 4'h1;
        if (h[10]) begin
          info_nxt.core = CORE_HIGH_QUALITY;
        end else begin
          info_nxt.core                  = CORE_TRANSFORM_EXCITE;
          info_nxt.transform_coder_class = h[9:8];
          info_nxt.signalling_bits       = SIG_13K2 + 4'h3;
          if (h[15:14] == BW_SUPER) begin
            info_nxt.ext = EXT_GAP_FILLING;
          end
        end
      end else if (h[15:14] != BW_NARROW) begin
        info_nxt.ext = h[10] ? EXT_FREQ_DOMAIN : EXT_TIME_DOMAIN;
        info_nxt.signalling_bits = SIG_13K2 + 4'h1;
      end
    end else if (n == LEN_16K4) begin
      info_nxt.rate              = RATE_16K4;
      info_nxt.bandwidth_field   = h[15:14];
      info_nxt.coder_class_field = {1'b0, h[12:10]};
      info_nxt.core = (h[12:10] == CT_16K4_TRANSFORM) ? CORE_TRANSFORM_EXCITE
                                                      : CORE_LINEAR_PREDICTION;
      if (h[15:14] == BW_SUPER || h[15:14] == BW_FULL) begin
        info_nxt.ext = (h[12:10] == CT_16K4_TRANSFORM) ? EXT_GAP_FILLING
                                                       : EXT_TIME_DOMAIN;
      end
      info_nxt.signalling_bits   = SIG_16K4;
    end else if (n == LEN_24K4) begin
      info_nxt.rate            = RATE_24K4;
      info_nxt.bandwidth_field = h[15:14];
      info_nxt.signalling_bits = SIG_24K4;
      if (!h[12]) begin
        info_nxt.coder_class_field = {2'b00, h[11:10]};
        info_nxt.signalling_bits   = SIG_24K4 + 4'h2;
      end else if (h[11]) begin
        info_nxt.core                   = CORE_HIGH_QUALITY;
        info_nxt.prev_linear_prediction = h[10];
        info_nxt.rate_16k               = h[10] & h[9];
        info_nxt.signalling_bits = h[10] ? SIG_24K4 + 4'h3 : SIG_24K4 + 4'h2;
      end else begin
        info_nxt.core                  = CORE_TRANSFORM_EXCITE;
        info_nxt.transform_coder_class = h[10:9];
        info_nxt.signalling_bits       = SIG_24K4 + 4'h3;
      end
      if ((h[15:14] == BW_SUPER || h[15:14] == BW_FULL)
          && !(h[12] && h[11])) begin
        info_nxt.ext = h[12] ? EXT_GAP_FILLING : EXT_TIME_DOMAIN;
      end
    end
  end

  // Frame result
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      info_r       <= '{rate: RATE_BAD, core: CORE_LINEAR_PREDICTION,
                        ext: EXT_NONE, bandwidth_field: '0,
                        coder_class_field: '0, transform_coder_class: '0,
                        prev_linear_prediction: 1'b0, rate_16k: 1'b0,
                        signalling_bits: '0};
      o_frame_done <= 1'b0;
      o_frame_bad  <= 1'b0;
    end else begin
      o_frame_done <= take_bit & i_bit_last;
      o_frame_bad  <= take_bit & i_bit_last & (info_nxt.rate == RATE_BAD);
      if (take_bit && i_bit_last) begin
        info_r <= info_nxt;
      end
    end
  end

  assign o_frame_info = info_r;

  // Frame counters; a clear request loses to a simultaneous frame end
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      good_count_r <= '0;
      bad_count_r  <= '0;
    end else if (o_frame_done) begin
      if (o_frame_bad) begin
        bad_count_r <= bad_count_r + 16'h0001;
      end else begin
        good_count_r <= good_count_r + 16'h0001;
      end
    end else if (i_psel && i_penable && i_pwrite && i_paddr == CTRL_OFFSET
                 && i_pwdata[CTRL_CLEAR_BIT]) begin
      good_count_r <= '0;
      bad_count_r  <= '0;
    end
  end

  // Control register: only the enable bit is stored
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ctrl_r <= CTRL_RESET;
    end else if (i_psel && i_penable && i_pwrite && i_paddr == CTRL_OFFSET) begin
      ctrl_r <= {31'h0000_0000, i_pwdata[CTRL_ENABLE_BIT]};
    end
  end

  // Read data and answer are registered in setup, so access has no wait
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= 1'b0;
      if (setup) begin
        if (i_paddr == CTRL_OFFSET) begin
          o_prdata <= ctrl_r;
        end else if (i_paddr == STATUS_OFFSET) begin
          o_prdata <= {bad_count_r, good_count_r};
        end else if (i_paddr == RESULT_OFFSET) begin
          o_prdata <= {3'b000, info_r};
        end else begin
          o_prdata  <= '0;
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  AST_BAD_LEN_FLAGGED: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && len_nxt != LEN_LOW_RATE && len_nxt != LEN_7K2
    && len_nxt != LEN_8K0 && len_nxt != LEN_9K6 && len_nxt != LEN_13K2
    && len_nxt != LEN_16K4 && len_nxt != LEN_24K4
    |=> o_frame_bad && o_frame_info.rate == RATE_BAD
        && o_frame_info.signalling_bits == 4'h0)
    else $error("unsupported length not flagged");

  AST_MSB_FIRST: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && !i_bit_last && len_r == 10'h000 |=> hdr_r[0] == $past(i_bit_data))
    else $error("first bit not captured at header head");

  AST_LOW_RATE: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && len_nxt == LEN_LOW_RATE
    |=> o_frame_info.rate == RATE_2K8
        && o_frame_info.coder_class_field[2:0] == $past(hdr_nxt[15:13]))
    else $error("low rate class wrong");

  AST_NO_EXT_LOW_BITRATE: assert property (@(posedge i_clock) disable iff (i_srst)
    o_frame_done && (o_frame_info.rate == RATE_7K2 || o_frame_info.rate == RATE_8K0)
    |-> o_frame_info.ext == EXT_NONE)
    else $error("extension at 7.2 or 8.0");

  AST_9K6_CORE: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && len_nxt == LEN_9K6
    |=> (o_frame_info.core == CORE_TRANSFORM_EXCITE)
        == ($past(hdr_nxt[13:11]) == CT_9K6_TRANSFORM))
    else $error("9.6 core choice wrong");

  AST_13K2_TCX_CLASS: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && len_nxt == LEN_13K2 && hdr_nxt[11] && !hdr_nxt[10]
    |=> o_frame_info.core == CORE_TRANSFORM_EXCITE
        && o_frame_info.transform_coder_class == $past(hdr_nxt[9:8]))
    else $error("13.2 transform class wrong");

  AST_24K4_HQ_RATE: assert property (@(posedge i_clock) disable iff (i_srst)
    o_frame_done && o_frame_info.rate == RATE_24K4
    && !o_frame_info.prev_linear_prediction |-> !o_frame_info.rate_16k)
    else $error("rate bit used without previous LP frame");

  AST_24K4_CORE_FLAG: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && len_nxt == LEN_24K4 && !hdr_nxt[12]
    |=> o_frame_info.core == CORE_LINEAR_PREDICTION)
    else $error("24.4 core flag ignored");

  AST_APB_ANSWER: assert property (@(posedge i_clock) disable iff (i_srst)
    setup ##1 i_psel && i_penable |-> o_pready)
    else $error("APB access not answered");

  AST_RATE_13K2: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && len_nxt == LEN_13K2
    |=> o_frame_done && !o_frame_bad && o_frame_info.rate == RATE_13K2)
    else $error("264 bit frame not decoded as 13.2");

  AST_RATE_16K4_24K4: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && (len_nxt == LEN_16K4 || len_nxt == LEN_24K4)
    |=> o_frame_info.rate == (($past(len_nxt) == LEN_16K4) ? RATE_16K4 : RATE_24K4))
    else $error("328 or 488 bit frame rate wrong");

  AST_JOINT_CORE: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && (len_nxt == LEN_7K2 || len_nxt == LEN_8K0)
    |=> (o_frame_info.core == CORE_HIGH_QUALITY) == $past(hdr_nxt[15]))
    else $error("joint index core choice wrong");

  AST_9K6_EXT: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && len_nxt == LEN_9K6
    && (hdr_nxt[15:14] == BW_WIDE || hdr_nxt[15:14] == BW_SUPER)
    |=> o_frame_info.ext != EXT_NONE)
    else $error("9.6 extension layer missing");

  AST_13K2_CORE_KIND: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && len_nxt == LEN_13K2 && hdr_nxt[11]
    |=> o_frame_info.core != CORE_LINEAR_PREDICTION)
    else $error("13.2 transform core not selected");

  AST_13K2_LP_EXT: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && len_nxt == LEN_13K2 && !hdr_nxt[11]
    && hdr_nxt[15:14] != BW_NARROW
    |=> o_frame_info.ext == EXT_TIME_DOMAIN || o_frame_info.ext == EXT_FREQ_DOMAIN)
    else $error("13.2 extension flag ignored");

  AST_HIGH_RATE_BAND: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && (len_nxt == LEN_16K4 || len_nxt == LEN_24K4)
    |=> o_frame_info.bandwidth_field == $past(hdr_nxt[15:14]))
    else $error("bandwidth field wrong at 16.4 or 24.4");

  AST_16K4_EXT: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && len_nxt == LEN_16K4 && hdr_nxt[15]
    |=> o_frame_info.ext != EXT_NONE)
    else $error("16.4 extension layer missing");

  AST_24K4_TCX_CLASS: assert property (@(posedge i_clock) disable iff (i_srst)
    take_bit && i_bit_last && len_nxt == LEN_24K4 && hdr_nxt[12] && !hdr_nxt[11]
    |=> o_frame_info.core == CORE_TRANSFORM_EXCITE
        && o_frame_info.transform_coder_class == $past(hdr_nxt[10:9]))
    else $error("24.4 transform class wrong");

endmodule : speech_frame_field_parser
